// file: hw/ta_defs.svh
`ifndef TA_DEFS_SVH
`define TA_DEFS_SVH

`define TA_CLK_MHZ 20
// arbitrary neutral value for the five fixed address bits
`define TA_DEV_ID 5'h0b
`define TA_RW_READ 1'b1
`define TA_HS_CODE 5'h01
`define TA_HS_LOW 3'h0
`define TA_BITS_FULL 4'hc
`define TA_BITS_CUT 4'h4
`define TA_LSB_PAD 4'h0
`define TA_ACK_BITNO 4'h8
`define TA_LAST_TX_BIT 4'h7
`define TA_READ_WAIT_NS 10000
`define TA_READ_WAIT_CYC ((`TA_READ_WAIT_NS * `TA_CLK_MHZ + 999) / 1000)
`define TA_QTR_STD_NS 2500
`define TA_QTR_STD_CYC ((`TA_QTR_STD_NS * `TA_CLK_MHZ + 999) / 1000)
`define TA_QTR_HS_NS 150
`define TA_QTR_HS_CYC ((`TA_QTR_HS_NS * `TA_CLK_MHZ + 999) / 1000)
`define TA_STG_CODE 2'h0
`define TA_STG_ADDR 2'h1
`define TA_STG_DATA 2'h2

`endif

// file: hw/ta_dev.sv
`include "ta_defs.svh"
`default_nettype none
// Behaviour
// - master idles, waits 10 us before reading
// - master may read early at lower accuracy
// - master sends start, address, read bit
// - acknowledge only a matching address
// - first byte is D11..D4, msb first
// - release data line for master acknowledge
// - second byte is D3..D0 then zeros
// - master ends with not-acknowledge
// - bytes repeat while master acknowledges
// - master closes read with stop
// - high-speed code never acknowledged
// - high-speed holds until stop
// - master uses repeated starts in high-speed
// - hold clock low until result latched
// - release clock once result latched
// - results are straight unsigned binary
// - 8-bit mode delivers one byte
// - 8-bit conversion takes four fewer decisions
// - resolution bit selects 12 or 8 bits
// - conversion starts when acquisition ends
module ta_dev (
  input wire logic clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic [11:0] result,
  input wire logic result_valid,
  input wire logic mode_8bit,
  input wire logic acq_end,
  input wire logic [1:0] addr_sel,
  output logic conv_start,
  output logic [3:0] conv_bits,
  output logic hs_mode,
  ta_i2c_if.device bus
);

  function automatic logic [3:0] bit_count(input logic m8);
    bit_count = m8 ? 4'(`TA_BITS_FULL - `TA_BITS_CUT) : `TA_BITS_FULL;
  endfunction

  function automatic logic [7:0] tx_byte(input logic [11:0] d, input logic lo);
    tx_byte = lo ? {d[3:0], `TA_LSB_PAD} : d[11:4];
  endfunction

  function automatic ta_pkg::ta_link_s load_byte(input ta_pkg::ta_link_s s);
    load_byte = s;
    load_byte.sh = tx_byte(s.data, s.second);
    load_byte.sda_oe = ~load_byte.sh[7];
    load_byte.bcnt = 4'h0;
    load_byte.scl_oe = 1'b0;
    load_byte.st = ta_pkg::TA_D_TX;
  endfunction

  ta_pkg::ta_conv_s c;
  ta_pkg::ta_conv_s next_c;
  ta_pkg::ta_link_s l;
  ta_pkg::ta_link_s next_l;
  logic lrst_s1;
  logic lrst;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  // converter side
  always_comb begin
    next_c = c;
    next_c.conv_start = acq_end;
    if (acq_end) begin
      next_c.mode = mode_8bit;
      next_c.acq_tgl = ~c.acq_tgl;
    end
    next_c.bits = bit_count(next_c.mode);
    if (result_valid) begin
      next_c.hold_res = result;
      next_c.hold_mode = c.mode;
      next_c.res_tgl = ~c.res_tgl;
    end
    next_c.hs_s1 = l.hs;
    next_c.hs_s2 = c.hs_s1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end

  // reset release aligned to the link clock
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      lrst_s1 <= 1'b1;
      lrst <= 1'b1;
    end else begin
      lrst_s1 <= 1'b0;
      lrst <= lrst_s1;
    end
  end

  assign scl_rise = l.scl_s2 && !l.scl_p;
  assign scl_fall = !l.scl_s2 && l.scl_p;
  assign start_c = l.scl_s2 && l.scl_p && l.sda_p && !l.sda_s2;
  assign stop_c = l.scl_s2 && l.scl_p && !l.sda_p && l.sda_s2;

  // link side
  always_comb begin
    next_l = l;
    next_l.scl_s1 = bus.scl;
    next_l.scl_s2 = l.scl_s1;
    next_l.scl_p = l.scl_s2;
    next_l.sda_s1 = bus.sda;
    next_l.sda_s2 = l.sda_s1;
    next_l.sda_p = l.sda_s2;
    next_l.rt_s1 = c.res_tgl;
    next_l.rt_s2 = l.rt_s1;
    next_l.rt_p = l.rt_s2;
    next_l.at_s1 = c.acq_tgl;
    next_l.at_s2 = l.at_s1;
    next_l.at_p = l.at_s2;
    next_l.sel_s1 = addr_sel;
    next_l.sel_s2 = l.sel_s1;
    if (l.at_s2 != l.at_p) begin
      next_l.ready = 1'b0;
    end
    // new result wins over a same-cycle conversion start
    if (l.rt_s2 != l.rt_p) begin
      next_l.data = c.hold_res;
      next_l.dmode = c.hold_mode;
      next_l.ready = 1'b1;
    end
    if (stop_c) begin
      next_l.st = ta_pkg::TA_D_IDLE;
      next_l.hs = 1'b0;
      next_l.sda_oe = 1'b0;
      next_l.scl_oe = 1'b0;
    end else if (start_c) begin
      next_l.st = ta_pkg::TA_D_ADDR;
      next_l.bcnt = 4'h0;
      next_l.sda_oe = 1'b0;
      next_l.scl_oe = 1'b0;
    end else begin
      unique case (l.st)
        ta_pkg::TA_D_IDLE: begin
          next_l.sda_oe = 1'b0;
          next_l.scl_oe = 1'b0;
        end
        ta_pkg::TA_D_ADDR: begin
          if (scl_rise && l.bcnt < `TA_ACK_BITNO) begin
            next_l.sh = {l.sh[6:0], l.sda_s2};
            next_l.bcnt = l.bcnt + 4'h1;
          end
          if (scl_fall && l.bcnt == `TA_ACK_BITNO) begin
            if (l.sh[7:3] == `TA_HS_CODE) begin
              next_l.hs = 1'b1;
              next_l.st = ta_pkg::TA_D_IDLE;
            end else if (l.sh[7:1] == {`TA_DEV_ID, l.sel_s2} && l.sh[0] == `TA_RW_READ) begin
              next_l.sda_oe = 1'b1;
              next_l.st = ta_pkg::TA_D_AACK;
            end else begin
              next_l.st = ta_pkg::TA_D_IDLE;
            end
          end
        end
        ta_pkg::TA_D_AACK: begin
          if (scl_fall) begin
            next_l.second = 1'b0;
            if (l.ready) begin
              next_l = load_byte(next_l);
            end else begin
              next_l.sda_oe = 1'b0;
              next_l.bcnt = 4'h0;
              next_l.scl_oe = 1'b1;
              next_l.st = ta_pkg::TA_D_STRETCH;
            end
          end
        end
        ta_pkg::TA_D_STRETCH: begin
          if (next_l.ready) begin
            next_l = load_byte(next_l);
            // first data bit settles two cycles before clock release
            if (l.bcnt != 4'h2) begin
              next_l.bcnt = l.bcnt + 4'h1;
              next_l.scl_oe = 1'b1;
              next_l.st = ta_pkg::TA_D_STRETCH;
            end
          end
        end
        ta_pkg::TA_D_TX: begin
          if (scl_fall) begin
            if (l.bcnt == `TA_LAST_TX_BIT) begin
              next_l.sda_oe = 1'b0;
              next_l.st = ta_pkg::TA_D_RACK;
            end else begin
              next_l.bcnt = l.bcnt + 4'h1;
              next_l.sh = {l.sh[6:0], 1'b0};
              next_l.sda_oe = ~l.sh[6];
            end
          end
        end
        ta_pkg::TA_D_RACK: begin
          if (scl_rise) begin
            next_l.ackd = ~l.sda_s2;
          end
          if (scl_fall) begin
            if (l.ackd) begin
              // one byte only in 8-bit mode, else alternate
              next_l.second = l.dmode ? 1'b0 : ~l.second;
              next_l = load_byte(next_l);
            end else begin
              next_l.st = ta_pkg::TA_D_IDLE;
            end
          end
        end
        default: begin
          next_l.st = ta_pkg::TA_D_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  assign bus.scl_d_o = 1'b0;
  assign bus.sda_d_o = 1'b0;
  assign bus.scl_d_oe = l.scl_oe;
  assign bus.sda_d_oe = l.sda_oe;
  assign conv_start = c.conv_start;
  assign conv_bits = c.bits;
  assign hs_mode = c.hs_s2;

endmodule
`default_nettype wire

// file: hw/ta_i2c_if.sv
`default_nettype none
interface ta_i2c_if;
  logic scl;
  logic sda;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic scl_d_o;
  logic scl_d_oe;
  logic sda_d_o;
  logic sda_d_oe;

  // wired-and with pull-up
  assign scl = !(scl_m_oe && !scl_m_o) && !(scl_d_oe && !scl_d_o);
  assign sda = !(sda_m_oe && !sda_m_o) && !(sda_d_oe && !sda_d_o);

  modport master (
    input scl,
    input sda,
    output scl_m_o,
    output scl_m_oe,
    output sda_m_o,
    output sda_m_oe
  );

  modport device (
    input scl,
    input sda,
    output scl_d_o,
    output scl_d_oe,
    output sda_d_o,
    output sda_d_oe
  );
endinterface
`default_nettype wire

// file: hw/ta_mst.sv
`include "ta_defs.svh"
`default_nettype none
module ta_mst (
  input wire logic clk,
  input wire logic reset,
  input wire logic go,
  input wire logic [1:0] addr_sel,
  input wire logic use_hs,
  input wire logic [1:0] rd_len,
  output logic busy,
  output logic done,
  output logic addr_nack,
  output logic [15:0] rd_data,
  ta_i2c_if.master bus
);

  ta_pkg::ta_mst_s m;
  ta_pkg::ta_mst_s next_m;
  logic [5:0] qtr;
  logic stall;
  logic step;
  logic tx;

  assign qtr = m.hs ? 6'(`TA_QTR_HS_CYC - 1) : 6'(`TA_QTR_STD_CYC - 1);
  // released clock held low by the device stops the quarter count
  assign stall = !m.scl_oe && !m.scl_s2;
  assign step = !stall && m.qcnt == qtr;
  assign tx = m.stage != `TA_STG_DATA;

  always_comb begin
    next_m = m;
    next_m.done = 1'b0;
    next_m.scl_s1 = bus.scl;
    next_m.scl_s2 = m.scl_s1;
    next_m.sda_s1 = bus.sda;
    next_m.sda_s2 = m.sda_s1;
    if (m.st != ta_pkg::TA_M_IDLE && m.st != ta_pkg::TA_M_WAIT && !stall) begin
      next_m.qcnt = step ? 6'h00 : m.qcnt + 6'h01;
      if (step) begin
        next_m.ph = m.ph + 2'h1;
      end
    end
    unique case (m.st)
      ta_pkg::TA_M_IDLE: begin
        if (go) begin
          next_m.sel = addr_sel;
          next_m.len = rd_len;
          next_m.hs_req = use_hs;
          next_m.nack = 1'b0;
          next_m.wcnt = 8'h00;
          next_m.st = ta_pkg::TA_M_WAIT;
        end
      end
      ta_pkg::TA_M_WAIT: begin
        next_m.wcnt = m.wcnt + 8'h01;
        if (m.wcnt == 8'(`TA_READ_WAIT_CYC - 1)) begin
          next_m.st = ta_pkg::TA_M_START;
          next_m.ph = 2'h0;
          next_m.qcnt = 6'h00;
          next_m.stage = m.hs_req ? `TA_STG_CODE : `TA_STG_ADDR;
        end
      end
      ta_pkg::TA_M_START: begin
        if (step && m.ph == 2'h3) begin
          next_m.st = ta_pkg::TA_M_BYTE;
          next_m.bitn = 4'h0;
          next_m.sh = (m.stage == `TA_STG_CODE) ? {`TA_HS_CODE, `TA_HS_LOW}
                                                : {`TA_DEV_ID, m.sel, `TA_RW_READ};
        end
      end
      ta_pkg::TA_M_BYTE: begin
        if (step && m.ph == 2'h3) begin
          next_m.bitn = m.bitn + 4'h1;
          if (m.bitn < `TA_ACK_BITNO) begin
            next_m.sh = {m.sh[6:0], m.sda_s2};
          end else begin
            next_m.bitn = 4'h0;
            unique case (m.stage)
              `TA_STG_CODE: begin
                next_m.hs = 1'b1;
                next_m.stage = `TA_STG_ADDR;
                next_m.st = ta_pkg::TA_M_START;
              end
              `TA_STG_ADDR: begin
                if (m.sda_s2) begin
                  next_m.nack = 1'b1;
                  next_m.st = ta_pkg::TA_M_STOP;
                end else begin
                  next_m.stage = `TA_STG_DATA;
                  next_m.nbyte = 2'h0;
                end
              end
              default: begin
                if (m.nbyte[0]) begin
                  next_m.rd_data[7:0] = m.sh;
                end else begin
                  next_m.rd_data[15:8] = m.sh;
                end
                if (m.nbyte == m.len) begin
                  next_m.st = ta_pkg::TA_M_STOP;
                end else begin
                  next_m.nbyte = m.nbyte + 2'h1;
                end
              end
            endcase
          end
        end
      end
      ta_pkg::TA_M_STOP: begin
        if (step && m.ph == 2'h3) begin
          next_m.st = ta_pkg::TA_M_IDLE;
          next_m.done = 1'b1;
          next_m.hs = 1'b0;
        end
      end
      default: begin
        next_m.st = ta_pkg::TA_M_IDLE;
      end
    endcase
    // pin drive; data bits move a quarter after the clock falls, start and stop edges at ph 3 while it is high
    unique case (next_m.st)
      ta_pkg::TA_M_START: begin
        next_m.scl_oe = next_m.ph < 2'h2;
        if (next_m.ph == 2'h1) begin
          next_m.sda_oe = 1'b0;
        end else if (next_m.ph == 2'h3) begin
          next_m.sda_oe = 1'b1;
        end
      end
      ta_pkg::TA_M_BYTE: begin
        next_m.scl_oe = next_m.ph < 2'h2;
        if (next_m.ph != 2'h0) begin
          if (next_m.bitn < `TA_ACK_BITNO) begin
            next_m.sda_oe = tx && !next_m.sh[7];
          end else begin
            next_m.sda_oe = !tx && next_m.nbyte != next_m.len;
          end
        end
      end
      ta_pkg::TA_M_STOP: begin
        next_m.scl_oe = next_m.ph < 2'h2;
        if (next_m.ph == 2'h1) begin
          next_m.sda_oe = 1'b1;
        end else if (next_m.ph == 2'h3) begin
          next_m.sda_oe = 1'b0;
        end
      end
      default: begin
        next_m.scl_oe = 1'b0;
        next_m.sda_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      m <= '0;
    end else begin
      m <= next_m;
    end
  end

  assign bus.scl_m_o = 1'b0;
  assign bus.sda_m_o = 1'b0;
  assign bus.scl_m_oe = m.scl_oe;
  assign bus.sda_m_oe = m.sda_oe;
  assign busy = m.st != ta_pkg::TA_M_IDLE;
  assign done = m.done;
  assign addr_nack = m.nack;
  assign rd_data = m.rd_data;

endmodule
`default_nettype wire

// file: hw/ta_pkg.sv
`default_nettype none
package ta_pkg;

  typedef enum logic [2:0] {
    TA_D_IDLE = 3'h0,
    TA_D_ADDR = 3'h1,
    TA_D_AACK = 3'h3,
    TA_D_STRETCH = 3'h2,
    TA_D_TX = 3'h6,
    TA_D_RACK = 3'h7
  } ta_dev_st_e;

  typedef enum logic [2:0] {
    TA_M_IDLE = 3'h0,
    TA_M_WAIT = 3'h1,
    TA_M_START = 3'h3,
    TA_M_BYTE = 3'h2,
    TA_M_STOP = 3'h6
  } ta_mst_st_e;

  typedef struct packed {
    logic mode;
    logic conv_start;
    logic [3:0] bits;
    logic [11:0] hold_res;
    logic hold_mode;
    logic res_tgl;
    logic acq_tgl;
    logic hs_s1;
    logic hs_s2;
  } ta_conv_s;

  typedef struct packed {
    ta_dev_st_e st;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic [11:0] data;
    logic dmode;
    logic ready;
    logic second;
    logic ackd;
    logic hs;
    logic scl_s1;
    logic scl_s2;
    logic scl_p;
    logic sda_s1;
    logic sda_s2;
    logic sda_p;
    logic rt_s1;
    logic rt_s2;
    logic rt_p;
    logic at_s1;
    logic at_s2;
    logic at_p;
    logic [1:0] sel_s1;
    logic [1:0] sel_s2;
    logic scl_oe;
    logic sda_oe;
  } ta_link_s;

  typedef struct packed {
    ta_mst_st_e st;
    logic [1:0] ph;
    logic [5:0] qcnt;
    logic [7:0] wcnt;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [1:0] stage;
    logic [1:0] nbyte;
    logic [1:0] len;
    logic [1:0] sel;
    logic hs_req;
    logic hs;
    logic scl_oe;
    logic sda_oe;
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic [15:0] rd_data;
    logic done;
    logic nack;
  } ta_mst_s;

endpackage
`default_nettype wire

// file: verif/ta_i2c_properties.sv
`default_nettype none
module ta_i2c_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_m_oe,
  input wire logic sda_m_oe,
  input wire logic scl_d_oe,
  input wire logic sda_d_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // scl rises since the last start
  logic [3:0] bits_seen;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bits_seen <= 4'h0;
    end else if ($fell(sda) && scl && $past(scl)) begin
      bits_seen <= 4'h0;
    end else if ($rose(scl) && bits_seen != 4'hf) begin
      bits_seen <= bits_seen + 4'h1;
    end
  end

  a_dev_sda_moves: assert property ($changed(sda_d_oe) |-> !scl)
    else $error("device moved sda while scl high");
  a_ack_no_fight: assert property (scl && sda_m_oe |-> !sda_d_oe)
    else $error("device drove sda over master bit");
  a_tx_no_fight: assert property (scl && sda_d_oe |-> !sda_m_oe)
    else $error("master drove sda over device bit");
  a_stretch_begin: assert property ($rose(scl_d_oe) |-> !$past(scl))
    else $error("stretch began while scl high");
  a_stretch_release: assert property ($fell(scl_d_oe) |-> ##[0:120] scl)
    else $error("scl not high after stretch release");
  a_start_by_master: assert property ($fell(sda) && scl && $past(scl) |-> sda_m_oe)
    else $error("start not made by master");
  a_stop_quiet: assert property ($rose(sda) && scl && $past(scl)
    |=> (!sda_d_oe && !scl_d_oe) [*4])
    else $error("device active after stop");
  a_addr_listen: assert property (bits_seen < 4'h8 |-> !sda_d_oe)
    else $error("device drove sda during first byte");

  c_stretch: cover property ($rose(scl_d_oe));
  c_dev_bit: cover property (scl && sda_d_oe);
  c_stop: cover property ($rose(sda) && scl && $past(scl));
endmodule
`default_nettype wire

// file: verif/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [15:0] data;
    logic [15:0] mask;
    logic nack;
    logic hs;
  } ta_note_s;

  logic clk, reset, link_clk, result_valid, mode_8bit, acq_end, conv_start, hs_mode;
  logic go, use_hs, busy, done, addr_nack, hs_seen;
  logic [11:0] result;
  logic [3:0] conv_bits;
  logic [1:0] dsel, msel, rd_len;
  logic [15:0] rd_data;
  int bad_count, n_tests, cyc, i;
  int seed = 32'h50198e84;
  ta_note_s notes[$];
  ta_note_s cur;

  always #25 clk = ~clk;
  always begin
    #3 link_clk = ~link_clk;
    #13;
  end

  ta_i2c_if i_ta_i2c_if ();
  ta_dev i_ta_dev (.clk(clk), .reset(reset), .link_clk(link_clk), .result(result),
    .result_valid(result_valid), .mode_8bit(mode_8bit), .acq_end(acq_end),
    .addr_sel(dsel), .conv_start(conv_start), .conv_bits(conv_bits),
    .hs_mode(hs_mode), .bus(i_ta_i2c_if));
  ta_mst i_ta_mst (.clk(clk), .reset(reset), .go(go), .addr_sel(msel), .use_hs(use_hs),
    .rd_len(rd_len), .busy(busy), .done(done), .addr_nack(addr_nack),
    .rd_data(rd_data), .bus(i_ta_i2c_if));
  ta_i2c_properties i_ta_i2c_properties (.clk(clk), .reset(reset),
    .scl(i_ta_i2c_if.scl), .sda(i_ta_i2c_if.sda),
    .scl_m_oe(i_ta_i2c_if.scl_m_oe), .sda_m_oe(i_ta_i2c_if.sda_m_oe),
    .scl_d_oe(i_ta_i2c_if.scl_d_oe), .sda_d_oe(i_ta_i2c_if.sda_d_oe));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic pulse_valid;
    result_valid = 1'b1;
    @(negedge clk);
    result_valid = 1'b0;
  endtask

  // lag 0: result ready before go, else result arrives mid-read
  task automatic xfer(input logic [1:0] ms, input logic h, input logic [1:0] len,
      input logic m, input logic [11:0] r, input int lag);
    ta_note_s n;
    int k;
    acq_end = 1'b1;
    mode_8bit = m;
    @(negedge clk);
    acq_end = 1'b0;
    k = 0;
    repeat (3) begin
      k += (conv_start === 1'b1);
      @(negedge clk);
    end
    cmp("conv_start", 16'h0001, 16'(k));
    cmp("conv_bits", m ? 16'h0008 : 16'h000c, {12'h000, conv_bits});
    result = r;
    repeat (10) @(negedge clk);
    if (lag == 0) begin
      pulse_valid();
      repeat (20) @(negedge clk);
    end
    n.nack = (ms !== dsel);
    n.hs = h;
    n.mask = n.nack ? 16'h0000 : (len == 2'h0 ? 16'hff00 : 16'hffff);
    n.data = {r[11:4], m ? r[11:4] : {r[3:0], 4'h0}};
    notes.push_back(n);
    msel = ms;
    use_hs = h;
    rd_len = len;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    cmp("busy", 16'h0001, {15'h0000, busy});
    if (lag != 0) begin
      repeat (lag) @(negedge clk);
      pulse_valid();
    end
    while (done !== 1'b1) @(negedge clk);
    repeat (20) @(negedge clk);
    cmp("hs_mode", 16'h0000, {15'h0000, hs_mode});
    cmp("busy", 16'h0000, {15'h0000, busy});
  endtask

  always @(posedge clk) begin
    if (reset === 1'b1 || go === 1'b1) begin
      hs_seen <= 1'b0;
    end else if (hs_mode === 1'b1) begin
      hs_seen <= 1'b1;
    end
  end

  always @(negedge clk) begin
    if (done === 1'b1) begin
      if (notes.size() == 0) begin
        bad_count++;
        $display("[FAIL] done expected 0 seen 1");
      end else begin
        cur = notes.pop_front();
        cmp("rd_data", cur.data & cur.mask, rd_data & cur.mask);
        cmp("addr_nack", {15'h0000, cur.nack}, {15'h0000, addr_nack});
        cmp("hs_seen", {15'h0000, cur.hs}, {15'h0000, hs_seen});
      end
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      bad_count++;
      $display("[FAIL] cycles expected below 100000 seen %0d", cyc);
      end_of_test();
    end
  end

  initial begin
    clk = 1'b0;
    link_clk = 1'b0;
    reset = 1'b1;
    result = 12'h000;
    result_valid = 1'b0;
    mode_8bit = 1'b0;
    acq_end = 1'b0;
    dsel = 2'h2;
    go = 1'b0;
    msel = 2'h2;
    use_hs = 1'b0;
    rd_len = 2'h0;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    xfer(2'h2, 1'b0, 2'h1, 1'b0, 12'hfff, 3000);
    xfer(2'h2, 1'b0, 2'h3, 1'b0, 12'h000, 0);
    xfer(2'h2, 1'b0, 2'h0, 1'b1, 12'ha50, 0);
    xfer(2'h2, 1'b1, 2'h2, 1'b1, 12'h3c0, 0);
    xfer(2'h2, 1'b1, 2'h1, 1'b0, 12'h5a3, 3000);
    xfer(2'h1, 1'b0, 2'h1, 1'b0, 12'h123, 0);
    for (i = 0; i < 3; i++) begin
      dsel = 2'($random(seed));
      xfer(dsel, 1'($random(seed)), 2'($random(seed)), 1'($random(seed)),
        12'($random(seed)), 0);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
